// ### hdl/wdcr_params.svh
// Constants for the watchdog control block
`ifndef WDCR_PARAMS_SVH
`define WDCR_PARAMS_SVH

// APB byte addresses
`define WDCR_ADDR_W       12
`define WDCR_ADDR_KEY     12'h0C4
`define WDCR_ADDR_CTRL    12'h0D8
`define WDCR_ADDR_COUNT   12'h0DC

// Control register bit positions
`define WDCR_B_BAUD       7
`define WDCR_B_POR        6
`define WDCR_B_WATCHDOG_INTERRUPT_FLAG       3
`define WDCR_B_WATCHDOG_RESET_FLAG       2
`define WDCR_B_EWT        1
`define WDCR_B_RWT        0

// Unlock keys
`define WDCR_KEY_FIRST    8'hAA
`define WDCR_KEY_SECOND   8'h55

// Timing
`define WDCR_MC_CLOCKS    4
`define WDCR_TA_MCYCLES   3
`define WDCR_TA_WINDOW    (`WDCR_MC_CLOCKS * `WDCR_TA_MCYCLES)
`define WDCR_RESET_DELAY  512
`define WDCR_INT_STEP     3
`define WDCR_TBASE_LOG2   17

`endif

// ### hdl/wdcr_pkg.sv
// Types for the watchdog control block
package wdcr_pkg;

   typedef enum logic [2:0]
   {
      WDCR_TA_IDLE = 3'b001,
      WDCR_TA_HALF = 3'b010,
      WDCR_TA_OPEN = 3'b100
   } wdcr_ta_state_t;

   typedef enum logic [1:0]
   {
      WDCR_WD_RUN   = 2'b01,
      WDCR_WD_GRACE = 2'b10
   } wdcr_wd_phase_t;

endpackage

// ### hdl/wdcr_ta.sv
// Timed-access unlock sequencer for the protected control bits
`timescale 1ns/1ps
`include "wdcr_params.svh"

module wdcr_ta
   import wdcr_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       ce,
   // Register writes
   input  wire logic       key_wr,
   input  wire logic       key_hit,
   input  wire logic [7:0] key_data,
   // Unlock state
   output logic            window_open
);

   wdcr_ta_state_t state_q;
   logic [4:0]     win_q;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= WDCR_TA_IDLE;
         win_q   <= 5'h00;
      end
      else if (ce)
      begin
         if (key_wr && key_hit && key_data == `WDCR_KEY_FIRST)
         begin
            state_q <= WDCR_TA_HALF;
            win_q   <= 5'h00;
         end
         else
         begin
            unique case (state_q)
               WDCR_TA_IDLE:
               begin
                  state_q <= WDCR_TA_IDLE;
               end
               WDCR_TA_HALF:
               begin
                  // The second key must be the very next write
                  if (key_wr && key_hit && key_data == `WDCR_KEY_SECOND)
                  begin
                     state_q <= WDCR_TA_OPEN;
                     win_q   <= 5'(`WDCR_TA_WINDOW - 1);
                  end
                  else if (key_wr)
                  begin
                     state_q <= WDCR_TA_IDLE;
                  end
               end
               WDCR_TA_OPEN:
               begin
                  if (win_q == 5'h00)
                  begin
                     state_q <= WDCR_TA_IDLE;
                  end
                  else
                  begin
                     win_q <= win_q - 5'h01;
                  end
               end
               default:
               begin
                  state_q <= WDCR_TA_IDLE;
               end
            endcase
         end
      end
   end

   assign window_open = (state_q == WDCR_TA_OPEN);

endmodule

// ### hdl/wdcr_top.sv
// Watchdog control register, reset flags and watchdog time-out logic
`timescale 1ns/1ps
`include "wdcr_params.svh"

// How it works
// - Power-up sets power-on flag; software reads/writes
// - Only software write clears power-on flag
// - Time-out sets interrupt flag whether or not interrupt enabled
// - Time-out sets flag anyway; software clears
// - Watchdog reset sets reset flag; sticky
// - Power-on and power-down resets clear reset flag
// - External reset keeps reset flag
// - Reset enable low: watchdog leaves flag alone
// - Reset enable arms watchdog reset
// - Restart bit returns count to start
// - Restart bit clears itself after taking effect
// - Unserviced time-out raises interrupt when enabled
// - Watchdog reset exactly 512 clocks after time-out
// - External reset loads pattern 0x000xx0
// - Of the resets, only power-on clears reset enable
// - Protected bits written only inside unlock window
// - All bits readable; unprotected bits freely writable
// - Baud-double bit drives serial port output
// - Window stays open three machine cycles
module wdcr_top
   import wdcr_pkg::*;
#(
   parameter int TBASE_LOG2 = `WDCR_TBASE_LOG2
)
(
   // Clock, reset, enable
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    ce,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`WDCR_ADDR_W-1:0] paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // Reset sources
   input  wire logic                    ext_reset,
   input  wire logic                    power_down_reset,
   // Watchdog configuration
   input  wire logic                    watchdog_interrupt_enable,
   input  wire logic [1:0]              interval_sel,
   // Results
   output logic                         watchdog_irq,
   output logic                         watchdog_reset_out,
   output logic                         serial1_baud_double
);

   function automatic logic addr_hit(input logic [`WDCR_ADDR_W-1:0] a,
                                     input logic [`WDCR_ADDR_W-1:0] off);
      return a == off;
   endfunction

   function automatic logic [31:0] interval_limit(input logic [1:0] sel);
      int sh;
      sh = TBASE_LOG2 + `WDCR_INT_STEP * int'(sel);
      return (32'h0000_0001 << sh) - 32'h0000_0001;
   endfunction

   // Control register bits
   logic        baud_q;
   logic        por_q;
   logic        watchdog_interrupt_flag_q;
   logic        watchdog_reset_flag_q;
   logic        ewt_q;
   logic        rwt_q;

   // Watchdog state
   logic [31:0]    cnt_q;
   logic [9:0]     grace_q;
   wdcr_wd_phase_t phase_q;
   logic           irq_q;
   logic           wdrst_q;

   // Bus state
   logic [31:0] prdata_q;
   logic        valid_q;

   // Decode and events
   logic        access;
   logic        wr;
   logic        wr_ctrl;
   logic        wr_key;
   logic        mapped;
   logic        window_open;
   logic        prot_ok;
   logic        hw_rst;
   logic        sw_restart;
   logic        timeout;
   logic        wd_fire;
   logic        restart;
   logic [7:0]  ctrl_rd;
   logic [31:0] rd_mux;

   // APB handshake: one data-capture cycle, then ready
   assign access  = psel && penable;
   assign pready  = ce && valid_q;
   assign mapped  = addr_hit(paddr, `WDCR_ADDR_CTRL) ||
                    addr_hit(paddr, `WDCR_ADDR_KEY) ||
                    addr_hit(paddr, `WDCR_ADDR_COUNT);
   assign pslverr = access && pready && !mapped;
   assign wr      = access && pready && pwrite && mapped;
   assign wr_ctrl = wr && addr_hit(paddr, `WDCR_ADDR_CTRL);
   assign wr_key  = wr && addr_hit(paddr, `WDCR_ADDR_KEY);
   assign prot_ok = window_open;

   wdcr_ta u_ta
   (
      .clock       (clock),
      .nrst        (nrst),
      .ce          (ce),
      .key_wr      (wr),
      .key_hit     (wr_key),
      .key_data    (pwdata[7:0]),
      .window_open (window_open)
   );

   // Reset and restart events
   assign hw_rst     = ext_reset || power_down_reset;
   assign sw_restart = rwt_q;
   assign timeout    = (cnt_q == interval_limit(interval_sel)) && !sw_restart && !hw_rst;
   assign wd_fire    = (phase_q == WDCR_WD_GRACE) &&
                       (grace_q == 10'(`WDCR_RESET_DELAY - 1)) &&
                       ewt_q && !sw_restart && !hw_rst;
   assign restart    = sw_restart || hw_rst || wd_fire;

   // Read view of the control register; reserved bits read zero
   always_comb
   begin
      ctrl_rd                = 8'h00;
      ctrl_rd[`WDCR_B_BAUD]  = baud_q;
      ctrl_rd[`WDCR_B_POR]   = por_q;
      ctrl_rd[`WDCR_B_WATCHDOG_INTERRUPT_FLAG]  = watchdog_interrupt_flag_q;
      ctrl_rd[`WDCR_B_WATCHDOG_RESET_FLAG]  = watchdog_reset_flag_q;
      ctrl_rd[`WDCR_B_EWT]   = ewt_q;
      ctrl_rd[`WDCR_B_RWT]   = rwt_q;
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (addr_hit(paddr, `WDCR_ADDR_CTRL))
      begin
         rd_mux = {24'h00_0000, ctrl_rd};
      end
      else if (addr_hit(paddr, `WDCR_ADDR_KEY))
      begin
         rd_mux = {31'h0000_0000, window_open};
      end
      else if (addr_hit(paddr, `WDCR_ADDR_COUNT))
      begin
         rd_mux = cnt_q;
      end
   end

   // Bus read data and ready
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         valid_q  <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         valid_q  <= psel && !(penable && valid_q);
         prdata_q <= psel ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata = prdata_q;

   // Baud doubling bit, unprotected
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         baud_q <= 1'b0;
      end
      else if (ce)
      begin
         if (hw_rst || wd_fire)
         begin
            baud_q <= 1'b0;
         end
         else if (wr_ctrl)
         begin
            baud_q <= pwdata[`WDCR_B_BAUD];
         end
      end
   end

   assign serial1_baud_double = baud_q;

   // Power-on flag: set by power-up or a protected software write, cleared only by software
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         por_q <= 1'b1;
      end
      else if (ce)
      begin
         if (wr_ctrl && prot_ok)
         begin
            por_q <= pwdata[`WDCR_B_POR];
         end
      end
   end

   // Watchdog interrupt flag; a time-out wins over a clearing write
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         watchdog_interrupt_flag_q <= 1'b0;
      end
      else if (ce)
      begin
         if (hw_rst || wd_fire)
         begin
            watchdog_interrupt_flag_q <= 1'b0;
         end
         else if (timeout)
         begin
            watchdog_interrupt_flag_q <= 1'b1;
         end
         else if (wr_ctrl && prot_ok)
         begin
            watchdog_interrupt_flag_q <= pwdata[`WDCR_B_WATCHDOG_INTERRUPT_FLAG];
         end
      end
   end

   // Watchdog reset flag, unprotected; external reset leaves it
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         watchdog_reset_flag_q <= 1'b0;
      end
      else if (ce)
      begin
         if (power_down_reset)
         begin
            watchdog_reset_flag_q <= 1'b0;
         end
         else if (wd_fire)
         begin
            watchdog_reset_flag_q <= 1'b1;
         end
         else if (wr_ctrl && !ext_reset)
         begin
            watchdog_reset_flag_q <= pwdata[`WDCR_B_WATCHDOG_RESET_FLAG];
         end
      end
   end

   // Reset enable: protected software write; of the resets, only power-on clears it
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ewt_q <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_ctrl && prot_ok && !hw_rst && !wd_fire)
         begin
            ewt_q <= pwdata[`WDCR_B_EWT];
         end
      end
   end

   // Restart bit: one cycle high, then clears itself
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rwt_q <= 1'b0;
      end
      else if (ce)
      begin
         if (hw_rst || wd_fire || rwt_q)
         begin
            rwt_q <= 1'b0;
         end
         else if (wr_ctrl && prot_ok && pwdata[`WDCR_B_RWT])
         begin
            rwt_q <= 1'b1;
         end
      end
   end

   // Time-out counter
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (restart || timeout)
         begin
            cnt_q <= 32'h0000_0000;
         end
         else
         begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   // Grace period between time-out and watchdog reset
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_q <= WDCR_WD_RUN;
         grace_q <= 10'h000;
      end
      else if (ce)
      begin
         unique case (phase_q)
            WDCR_WD_RUN:
            begin
               if (timeout && ewt_q)
               begin
                  phase_q <= WDCR_WD_GRACE;
                  grace_q <= 10'h000;
               end
            end
            WDCR_WD_GRACE:
            begin
               // Dropping the enable or a restart abandons the reset
               if (restart || !ewt_q)
               begin
                  phase_q <= WDCR_WD_RUN;
                  grace_q <= 10'h000;
               end
               else
               begin
                  grace_q <= grace_q + 10'h001;
               end
            end
            default:
            begin
               phase_q <= WDCR_WD_RUN;
               grace_q <= 10'h000;
            end
         endcase
      end
   end

   // Interrupt and reset outputs
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_q   <= 1'b0;
         wdrst_q <= 1'b0;
      end
      else if (ce)
      begin
         irq_q   <= (watchdog_interrupt_flag_q || timeout) && watchdog_interrupt_enable && !hw_rst && !wd_fire;
         wdrst_q <= wd_fire;
      end
   end

   assign watchdog_irq       = irq_q;
   assign watchdog_reset_out = wdrst_q;

endmodule

// ### testbench/wdcr_properties.sv
// Port-level assertions for the watchdog control block
`timescale 1ns/1ps
`include "wdcr_params.svh"
module wdcr_properties
#(
   parameter int TBASE_LOG2 = 4
)
(
   // Clock and reset
   input wire logic                    clock,
   input wire logic                    nrst,
   input wire logic                    ce,
   // APB
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`WDCR_ADDR_W-1:0] paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // Reset sources and configuration
   input wire logic                    ext_reset,
   input wire logic                    power_down_reset,
   input wire logic                    watchdog_interrupt_enable,
   input wire logic [1:0]              interval_sel,
   // Results
   input wire logic                    watchdog_irq,
   input wire logic                    watchdog_reset_out,
   input wire logic                    serial1_baud_double
);
   logic done_w;
   logic hw_rst_w;
   assign done_w = psel && penable && pready && ce;
   assign hw_rst_w = ext_reset || power_down_reset;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   baud_follow_a:
      assert property (done_w && pwrite && paddr == `WDCR_ADDR_CTRL && !hw_rst_w
         |=> serial1_baud_double == $past(pwdata[7]) || watchdog_reset_out) else $error("baud output wrong");
   slverr_map_a:
      assert property (pslverr |-> done_w && !(paddr inside {`WDCR_ADDR_KEY, `WDCR_ADDR_CTRL, `WDCR_ADDR_COUNT}))
      else $error("error response on mapped address");
   reset_pulse_a:
      assert property (watchdog_reset_out && ce |=> !watchdog_reset_out) else $error("reset pulse too long");
   irq_gated_a:
      assert property (ce && !watchdog_interrupt_enable |=> !watchdog_irq) else $error("irq while disabled");
   rsvd_zero_a:
      assert property (done_w && !pwrite && paddr == `WDCR_ADDR_CTRL |-> prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0)
      else $error("reserved control bits not zero");
   baud_hwrst_a:
      assert property (ce && hw_rst_w |=> !serial1_baud_double) else $error("baud kept over reset");
   rstout_clr_a:
      assert property (watchdog_reset_out |-> !serial1_baud_double) else $error("baud kept over watchdog reset");
   ready_wait_a:
      assert property (psel && !penable && ce ##1 ce |-> pready) else $error("access phase not answered");
   fire_c: cover property ($rose(watchdog_reset_out));
   irq_c: cover property ($rose(watchdog_irq));
   err_c: cover property (pslverr);
endmodule

// ### testbench/wdcr_top_tb_top.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`include "wdcr_params.svh"
module wdcr_top_tb_top;
   logic                    clock;
   logic                    nrst;
   logic                    ce;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [`WDCR_ADDR_W-1:0] paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    ext_reset;
   logic                    power_down_reset;
   logic                    watchdog_interrupt_enable;
   logic [1:0]              interval_sel;
   logic                    watchdog_irq;
   logic                    watchdog_reset_out;
   logic                    serial1_baud_double;
   logic [31:0]             rdat;
   logic                    rerr;
   int                      fires;
   int                      error_cnt;
   int                      tests_run;
   int                      cyc;

   wdcr_top #(.TBASE_LOG2(4)) i_dut (.clock(clock), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_reset(ext_reset), .power_down_reset(power_down_reset), .interval_sel(interval_sel),
      .watchdog_interrupt_enable(watchdog_interrupt_enable), .watchdog_irq(watchdog_irq),
      .watchdog_reset_out(watchdog_reset_out), .serial1_baud_double(serial1_baud_double));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Hang guard and reset pulse monitor
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (watchdog_reset_out === 1'b1)
         fires <= fires + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; the answer is taken at the rising edge that samples pready high
   task automatic apb(input logic wr, input logic [`WDCR_ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1);
      chk("access cycles", 32'd1, n);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [`WDCR_ADDR_W-1:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [`WDCR_ADDR_W-1:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic unlock();
      wr(`WDCR_ADDR_KEY, `WDCR_KEY_FIRST);
      wr(`WDCR_ADDR_KEY, `WDCR_KEY_SECOND);
   endtask

   // Counts falling edges until the chosen output reaches the level
   task automatic wait_sig(input logic rst_sig, input logic v, output int n);
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end
      while ((rst_sig ? watchdog_reset_out : watchdog_irq) !== v && n < 2000);
   endtask

   task automatic t_access();
      rd(`WDCR_ADDR_CTRL);
      chk("ctrl after power-on", 32'h40, rdat);
      rd(12'h0F0);
      chk("unmapped error", 32'h1, {31'h0, rerr});
      wr(`WDCR_ADDR_CTRL, 8'h8B);
      rd(`WDCR_ADDR_CTRL);
      chk("locked write", 32'hC0, rdat);
      chk("baud out high", 32'h1, {31'h0, serial1_baud_double});
      unlock();
      wr(`WDCR_ADDR_CTRL, 8'h00);
      rd(`WDCR_ADDR_CTRL);
      chk("software clears flag", 32'h00, rdat);
      chk("baud out low", 32'h0, {31'h0, serial1_baud_double});
      unlock();
      repeat (14) @(posedge clock);
      wr(`WDCR_ADDR_CTRL, 8'h40);
      rd(`WDCR_ADDR_CTRL);
      chk("window closed", 32'h00, rdat);
      wr(`WDCR_ADDR_KEY, `WDCR_KEY_FIRST);
      wr(`WDCR_ADDR_CTRL, 8'h00);
      wr(`WDCR_ADDR_KEY, `WDCR_KEY_SECOND);
      wr(`WDCR_ADDR_CTRL, 8'h40);
      rd(`WDCR_ADDR_CTRL);
      chk("split key", 32'h00, rdat);
   endtask

   task automatic t_timeout();
      int n;
      logic [31:0] c1;
      interval_sel <= 2'd1;
      unlock();
      wr(`WDCR_ADDR_CTRL, 8'h01);
      rd(`WDCR_ADDR_CTRL);
      chk("restart self clears", 32'h0, rdat & 32'h1);
      rd(`WDCR_ADDR_COUNT);
      chk("count restarted", 32'h1, {31'h0, rdat < 32'd16});
      // Clock enable low must freeze the count
      c1 = rdat;
      @(posedge clock);
      ce <= 1'b0;
      repeat (20) @(posedge clock);
      ce <= 1'b1;
      rd(`WDCR_ADDR_COUNT);
      chk("count frozen", c1 + 32'd4, rdat);
      repeat (700) @(posedge clock);
      chk("irq disabled", 32'h0, {31'h0, watchdog_irq});
      chk("no fire disabled", 32'h0, fires);
      rd(`WDCR_ADDR_CTRL);
      chk("elapsed flag", 32'h08, rdat & 32'h0E);
      watchdog_interrupt_enable <= 1'b1;
      repeat (2) @(posedge clock);
      chk("irq enabled", 32'h1, {31'h0, watchdog_irq});
      unlock();
      wr(`WDCR_ADDR_CTRL, 8'h01);
      // Second clear lands while the fresh count is far from a time-out
      wr(`WDCR_ADDR_CTRL, 8'h00);
      wait_sig(1'b0, 1'b0, n);
      wait_sig(1'b0, 1'b1, n);
      chk("interval from select", 32'h1, {31'h0, n > 110 && n <= 128});
   endtask

   task automatic t_wdreset();
      int n;
      @(posedge clock);
      interval_sel <= 2'd0;
      unlock();
      wr(`WDCR_ADDR_CTRL, 8'h03);
      wr(`WDCR_ADDR_CTRL, 8'h02);
      wait_sig(1'b0, 1'b0, n);
      wait_sig(1'b0, 1'b1, n);
      wait_sig(1'b1, 1'b1, n);
      chk("reset delay", 32'd512, n);
      rd(`WDCR_ADDR_CTRL);
      chk("reset flag set", 32'h06, rdat & 32'h06);
      wr(`WDCR_ADDR_CTRL, 8'h84);
      @(posedge clock);
      ext_reset <= 1'b1;
      @(posedge clock);
      ext_reset <= 1'b0;
      rd(`WDCR_ADDR_CTRL);
      chk("external reset", 32'h06, rdat & 32'h87);
      @(posedge clock);
      power_down_reset <= 1'b1;
      @(posedge clock);
      power_down_reset <= 1'b0;
      rd(`WDCR_ADDR_CTRL);
      chk("power-down reset", 32'h02, rdat & 32'h06);
      interval_sel <= 2'd3;
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rd(`WDCR_ADDR_CTRL);
      chk("power-on clears enable", 32'h40, rdat);
   endtask

   initial
   begin
      {ce, psel, penable, pwrite, ext_reset, power_down_reset, watchdog_interrupt_enable} = 7'h40;
      {nrst, paddr, pwdata, interval_sel} = '0;
      {fires, error_cnt, tests_run, cyc} = '0;
      interval_sel = 2'd3;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      t_access();
      t_timeout();
      t_wdreset();
      end_sim();
   end
endmodule

bind wdcr_top wdcr_properties #(.TBASE_LOG2(TBASE_LOG2)) i_prop (.clock(clock), .nrst(nrst), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ext_reset(ext_reset), .power_down_reset(power_down_reset),
   .watchdog_interrupt_enable(watchdog_interrupt_enable), .interval_sel(interval_sel),
   .watchdog_irq(watchdog_irq), .watchdog_reset_out(watchdog_reset_out), .serial1_baud_double(serial1_baud_double));
